// ### logic/tlpt_pkg.sv
package tlpt_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam longint CLK_PERIOD_PS = 64'd5000;
  localparam longint SECOND_PS = 64'd1000000000000;
  localparam int SEC_CYCLES_DFLT = int'(SECOND_PS / CLK_PERIOD_PS);
  localparam logic [15:0] LLB_LIMIT_S = 16'h000a;
  localparam logic [8:0] DET_HOLD_BITS = 9'h100;
  localparam logic [4:0] MON_WARM_BITS = 5'h18;
  // ************************************************************
  // register offsets and fields
  // ************************************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_USER = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_LLB_SECS = 8'h10;
  localparam logic [7:0] OFS_PAT_SECS = 8'h14;
  localparam logic [7:0] OFS_ERR_CNT = 8'h18;
  localparam int CMD_LLB_UP = 0;
  localparam int CMD_LLB_DOWN = 1;
  localparam int CMD_SEND = 2;
  localparam int CMD_MON = 3;
  localparam int CMD_STOP = 4;
  localparam int CMD_ERR_INS = 5;
  localparam int CMD_MON_CLR = 6;
  localparam int CFG_TERM_LOOP = 0;
  localparam int CFG_SEND_PAT = 4;
  localparam int CFG_MON_PAT = 8;
  localparam int USR_SEND = 0;
  localparam int USR_MON = 16;
  localparam int ST_LLB = 0;
  localparam int ST_SEND = 4;
  localparam int ST_MON = 5;
  localparam int ST_V54 = 6;
  localparam int ST_FT1 = 7;
  localparam int ST_LINK_UP = 8;
  localparam int ST_REF_LLB = 9;
  localparam int ST_REF_PAT = 10;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] USER_RST = 32'ha0a0_a0a0;
  // ************************************************************
  // pattern selects
  // ************************************************************
  localparam logic [3:0] PAT_QUASI_RANDOM_PATTERN = 4'h0;
  localparam logic [3:0] PAT_ALL0 = 4'h1;
  localparam logic [3:0] PAT_ALL1 = 4'h2;
  localparam logic [3:0] PAT_1IN8 = 4'h3;
  localparam logic [3:0] PAT_3IN24 = 4'h4;
  localparam logic [3:0] PAT_63 = 4'h5;
  localparam logic [3:0] PAT_511 = 4'h6;
  localparam logic [3:0] PAT_2047 = 4'h7;
  localparam logic [3:0] PAT_2E15 = 4'h8;
  localparam logic [3:0] PAT_2E20 = 4'h9;
  localparam logic [3:0] PAT_USER = 4'ha;
  localparam logic [23:0] SEED_1IN8 = 24'h000080;
  localparam logic [23:0] SEED_3IN24 = 24'h440004;
  // ************************************************************
  // in-band codes, sent and matched msb first
  // ************************************************************
  localparam logic [15:0] LLB_UP_CODE = 16'h0001;
  localparam logic [3:0] LLB_UP_LEN = 4'h5;
  localparam logic [15:0] LLB_DOWN_CODE = 16'h0001;
  localparam logic [3:0] LLB_DOWN_LEN = 4'h3;
  localparam logic [15:0] V54_ACT_CODE = 16'h0071;
  localparam logic [15:0] V54_REL_CODE = 16'h000e;
  localparam int V54_LEN = 7;
  localparam logic [15:0] FT1_ACT_CODE = 16'h0012;
  // release must not be a rotation of activate, or one stream trips both detectors
  localparam logic [15:0] FT1_REL_CODE = 16'h002c;
  localparam int FT1_LEN = 8;
  typedef enum logic [3:0] {
    LLB_IDLE = 4'b0001,
    LLB_UP = 4'b0010,
    LLB_LOOPED = 4'b0100,
    LLB_DOWN = 4'b1000
  } tlpt_llb_t;
endpackage

// ### logic/tlpt_det_if.sv
`timescale 1ns/1ps
interface tlpt_det_if;
  logic bitEn;
  logic rxBit;
  logic found;
  modport det (input bitEn, input rxBit, output found);
  modport host (output bitEn, output rxBit, input found);
endinterface

// ### logic/tlpt_code_det.sv
`timescale 1ns/1ps
module tlpt_code_det
  import tlpt_pkg::*;
#(
  parameter logic [15:0] CODE = 16'h0001,
  parameter int LEN = 5
)
(
  input wire mclk,
  input wire rst_b,
  tlpt_det_if.det dp
);
  // ************************************************************
  // repeating-code detector
  // ************************************************************
  localparam logic [15:0] LEN_MASK = 16'((32'h1 << LEN) - 1);
  logic [15:0] hist_r;
  logic [8:0] run_r;
  logic seen_r;
  logic found_r;
  wire periodOk = dp.rxBit == hist_r[LEN-1];
  wire codeHit = (({hist_r[14:0], dp.rxBit}) & LEN_MASK) == (CODE & LEN_MASK);
  wire runFull = run_r == DET_HOLD_BITS;
  // a fixed-period run alone is not enough: the code must also show up in it
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hist_r <= 16'h0000;
      run_r <= 9'h000;
      seen_r <= 1'b0;
      found_r <= 1'b0;
    end
    else
    begin
      found_r <= 1'b0;
      if (dp.bitEn)
      begin
        hist_r <= {hist_r[14:0], dp.rxBit};
        if (!periodOk)
        begin
          run_r <= 9'h000;
          seen_r <= codeHit;
        end
        else
        begin
          if (!runFull)
            run_r <= run_r + 9'h001;
          seen_r <= seen_r | codeHit;
          found_r <= run_r == DET_HOLD_BITS - 9'h001 && (seen_r || codeHit);
        end
      end
    end
  end
  assign dp.found = found_r;
endmodule // tlpt_code_det

// ### logic/tlpt_top.sv
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - terminal loop on: received terminal bit goes back out that terminal port
// - a terminal loop on one port leaves the other port untouched
// - send command transmits the activate code putting the far unit in loop
// - release command transmits the release code taking the far unit out
// - code sent until far acknowledge or ten seconds, whichever first
// - elapsed seconds kept while the remote line loop test runs
// - remote line loop start refused while interface loops or sends busy
// - channel data loop returns received frame relay slot bits to network
// - v54 and fractional t1 codes both activate and release channel loop
// - frame relay link reported down while channel data loop active
// - generator and checker cover all listed fixed and random patterns
// - separate 16-bit user words for send and monitor, repeated
// - pattern send refused while loop or other send busy on interface
// - each error insert flips one transmitted pattern bit, merged with any insert still pending
// - pattern test keeps elapsed seconds and a bit error count
// - monitor count clear zeroes errors without stopping monitor
// - stop halts pattern send and monitor, status back to inactive
// - send and monitor are separate functions
// - insert only while sending; clear only while monitoring 511
module tlpt_top
  import tlpt_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DFLT
)
(
  input wire mclk,
  input wire rst_b,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output logic [31:0] regRdData,
  input wire netBitEn,
  input wire netRxBit,
  input wire netRxFrSlot,
  input wire netTxUserBit,
  output logic netTxBit,
  input wire farAck,
  input wire netLoopBusy,
  input wire syncPortBusy,
  input wire syncPatBusy,
  output logic frLinkUp,
  input wire [1:0] termRxBit,
  input wire [1:0] termTxUserBit,
  output logic [1:0] termTxBit
);
  // ************************************************************
  // pattern functions
  // ************************************************************
  // hist[0] is the newest bit; prbs taps read x^n + x^k + 1
  function automatic logic patRaw(input logic [3:0] sel, input logic [23:0] h);
    case (sel)
      PAT_QUASI_RANDOM_PATTERN: patRaw = h[16] ^ h[19];
      PAT_ALL0: patRaw = 1'b0;
      PAT_ALL1: patRaw = 1'b1;
      PAT_1IN8: patRaw = h[7];
      PAT_3IN24: patRaw = h[23];
      PAT_63: patRaw = h[4] ^ h[5];
      PAT_511: patRaw = h[4] ^ h[8];
      PAT_2047: patRaw = h[8] ^ h[10];
      PAT_2E15: patRaw = h[13] ^ h[14];
      PAT_2E20: patRaw = h[2] ^ h[19];
      PAT_USER: patRaw = h[15];
      default: patRaw = 1'b0;
    endcase
  endfunction
  // quasi_random_pattern forces a one after fourteen zeros
  function automatic logic patOut(input logic [3:0] sel, input logic [23:0] h);
    patOut = patRaw(sel, h) | (sel == PAT_QUASI_RANDOM_PATTERN && h[13:0] == 14'h0000);
  endfunction
  function automatic logic [23:0] patSeed(input logic [3:0] sel, input logic [15:0] user);
    case (sel)
      PAT_ALL0: patSeed = 24'h000000;
      PAT_1IN8: patSeed = SEED_1IN8;
      PAT_3IN24: patSeed = SEED_3IN24;
      PAT_USER: patSeed = {8'h00, user};
      default: patSeed = 24'hffffff;
    endcase
  endfunction
  // ************************************************************
  // register port decode
  // ************************************************************
  logic [1:0] termLoop_r;
  logic [3:0] sendPat_r;
  logic [3:0] monPat_r;
  logic [15:0] sendUser_r;
  logic [15:0] monUser_r;
  wire wrCmd = regWr && regAddr == OFS_CMD;
  wire cmdLlbUp = wrCmd && regWrData[CMD_LLB_UP];
  wire cmdLlbDown = wrCmd && regWrData[CMD_LLB_DOWN];
  wire cmdSend = wrCmd && regWrData[CMD_SEND];
  wire cmdMon = wrCmd && regWrData[CMD_MON];
  wire cmdStop = wrCmd && regWrData[CMD_STOP];
  wire cmdIns = wrCmd && regWrData[CMD_ERR_INS];
  wire cmdClr = wrCmd && regWrData[CMD_MON_CLR];
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      termLoop_r <= CFG_RST[CFG_TERM_LOOP +: 2];
      sendPat_r <= CFG_RST[CFG_SEND_PAT +: 4];
      monPat_r <= CFG_RST[CFG_MON_PAT +: 4];
      sendUser_r <= USER_RST[USR_SEND +: 16];
      monUser_r <= USER_RST[USR_MON +: 16];
    end
    else
    begin
      if (regWr && regAddr == OFS_CFG)
      begin
        termLoop_r <= regWrData[CFG_TERM_LOOP +: 2];
        sendPat_r <= regWrData[CFG_SEND_PAT +: 4];
        monPat_r <= regWrData[CFG_MON_PAT +: 4];
      end
      if (regWr && regAddr == OFS_USER)
      begin
        sendUser_r <= regWrData[USR_SEND +: 16];
        monUser_r <= regWrData[USR_MON +: 16];
      end
    end
  end
  // ************************************************************
  // terminal port loop
  // ************************************************************
  // no data source here: looped bits come only from the attached side
  wire [1:0] termNext = (termRxBit & termLoop_r) | (termTxUserBit & ~termLoop_r);
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      termTxBit <= 2'b00;
    else
      termTxBit <= termNext;
  end
  // ************************************************************
  // seconds tick and channel code detectors
  // ************************************************************
  logic [31:0] secCnt_r;
  wire secTick = secCnt_r == 32'(SEC_CYCLES - 1);
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      secCnt_r <= 32'h0000_0000;
    else
      secCnt_r <= secTick ? 32'h0000_0000 : secCnt_r + 32'h0000_0001;
  end
  localparam logic [15:0] DET_CODE [4] = '{V54_ACT_CODE, V54_REL_CODE, FT1_ACT_CODE, FT1_REL_CODE};
  localparam int DET_LEN [4] = '{V54_LEN, V54_LEN, FT1_LEN, FT1_LEN};
  logic [3:0] detFound;
  for (genvar i = 0; i < 4; i++)
  begin : g_det
    tlpt_det_if dIf ();
    assign dIf.bitEn = netBitEn && netRxFrSlot;
    assign dIf.rxBit = netRxBit;
    assign detFound[i] = dIf.found;
    tlpt_code_det #(.CODE(DET_CODE[i]), .LEN(DET_LEN[i])) u_det (
      .mclk(mclk),
      .rst_b(rst_b),
      .dp(dIf)
    );
  end
  logic dclbV54_r;
  logic dclbFt1_r;
  wire dclbActive = dclbV54_r || dclbFt1_r;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dclbV54_r <= 1'b0;
      dclbFt1_r <= 1'b0;
    end
    else
    begin
      if (detFound[0] || detFound[1])
        dclbV54_r <= detFound[0];
      if (detFound[2] || detFound[3])
        dclbFt1_r <= detFound[2];
    end
  end
  assign frLinkUp = !dclbActive;
  // ************************************************************
  // remote line loop code sender
  // ************************************************************
  tlpt_llb_t llbState_r;
  tlpt_llb_t llbState_nxt;
  logic [15:0] llbSecs_r;
  logic [3:0] codePhase_r;
  logic refLlb_r;
  logic sendActive_r;
  wire llbSending = llbState_r == LLB_UP || llbState_r == LLB_DOWN;
  wire llbIdle = llbState_r == LLB_IDLE;
  wire llbBlock = netLoopBusy || dclbActive || sendActive_r || syncPatBusy || syncPortBusy;
  wire llbDone = farAck || llbSecs_r >= LLB_LIMIT_S;
  wire [3:0] codeLen = llbState_r == LLB_DOWN ? LLB_DOWN_LEN : LLB_UP_LEN;
  wire [15:0] codeWord = llbState_r == LLB_DOWN ? LLB_DOWN_CODE : LLB_UP_CODE;
  wire codeBit = codeWord[4'(codeLen - 4'h1 - codePhase_r)];
  always_comb
  begin
    llbState_nxt = llbState_r;
    case (llbState_r)
      LLB_IDLE: if (cmdLlbUp && !llbBlock) llbState_nxt = LLB_UP;
      LLB_UP: if (cmdLlbDown) llbState_nxt = LLB_DOWN; else if (llbDone) llbState_nxt = LLB_LOOPED;
      LLB_LOOPED: if (cmdLlbDown) llbState_nxt = LLB_DOWN;
      LLB_DOWN: if (llbDone) llbState_nxt = LLB_IDLE;
      default: llbState_nxt = LLB_IDLE;
    endcase
  end
  wire llbPhaseChg = llbState_nxt != llbState_r;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      llbState_r <= LLB_IDLE;
      llbSecs_r <= 16'h0000;
      codePhase_r <= 4'h0;
      refLlb_r <= 1'b0;
    end
    else
    begin
      llbState_r <= llbState_nxt;
      if (llbPhaseChg && llbState_nxt != LLB_LOOPED)
        llbSecs_r <= 16'h0000;
      else if (secTick && !llbIdle && llbSecs_r != 16'hffff)
        llbSecs_r <= llbSecs_r + 16'h0001;
      if (llbPhaseChg)
        codePhase_r <= 4'h0;
      else if (netBitEn && llbSending)
        codePhase_r <= codePhase_r == codeLen - 4'h1 ? 4'h0 : codePhase_r + 4'h1;
      if (cmdLlbUp && llbIdle)
        refLlb_r <= llbBlock;
    end
  end
  // ************************************************************
  // pattern send
  // ************************************************************
  logic [23:0] sendHist_r;
  logic insPend_r;
  logic refPat_r;
  wire sendBlock = netLoopBusy || dclbActive || !llbIdle || syncPatBusy || syncPortBusy;
  wire sendStart = cmdSend && !sendActive_r && !cmdStop;
  wire dclbSlot = dclbActive && netRxFrSlot;
  // history keeps the pattern bits before error insert, so the monitor can rebuild it from the line
  wire sendRaw = patOut(sendPat_r, sendHist_r);
  wire sendBit = patOut(sendPat_r, sendHist_r) ^ insPend_r;
  wire insUsed = netBitEn && sendActive_r && !dclbSlot;
  wire txNext = dclbSlot ? netRxBit : sendActive_r ? sendBit : llbSending ? codeBit : netTxUserBit;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sendActive_r <= 1'b0;
      sendHist_r <= 24'h000000;
      insPend_r <= 1'b0;
      refPat_r <= 1'b0;
      netTxBit <= 1'b0;
    end
    else
    begin
      if (netBitEn)
        netTxBit <= txNext;
      if (cmdStop)
        sendActive_r <= 1'b0;
      else if (sendStart)
        sendActive_r <= !sendBlock;
      if (sendStart)
        refPat_r <= sendBlock;
      if (sendStart)
        sendHist_r <= patSeed(sendPat_r, sendUser_r);
      else if (insUsed)
        sendHist_r <= {sendHist_r[22:0], sendRaw};
      // a request landing on the bit that uses the last one stays pending
      if (cmdIns && sendActive_r)
        insPend_r <= 1'b1;
      else if (insUsed || !sendActive_r)
        insPend_r <= 1'b0;
    end
  end
  // ************************************************************
  // pattern monitor
  // ************************************************************
  logic monActive_r;
  logic [23:0] monHist_r;
  logic [4:0] monWarm_r;
  logic [19:0] errCnt_r;
  logic [15:0] patSecs_r;
  // every pattern self-syncs from the line, whatever its phase; early bits not judged
  wire monReady = monWarm_r == MON_WARM_BITS;
  wire monBitErr = netBitEn && monActive_r && monReady && netRxBit != patOut(monPat_r, monHist_r);
  wire monClrOk = cmdClr && monActive_r && monPat_r == PAT_511;
  wire monStart = cmdMon && !cmdStop;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      monActive_r <= 1'b0;
      monHist_r <= 24'h000000;
      monWarm_r <= 5'h00;
      errCnt_r <= 20'h00000;
      patSecs_r <= 16'h0000;
    end
    else
    begin
      if (cmdStop)
        monActive_r <= 1'b0;
      else if (monStart)
        monActive_r <= 1'b1;
      if (monStart)
      begin
        monHist_r <= patSeed(monPat_r, monUser_r);
        monWarm_r <= 5'h00;
      end
      else if (netBitEn && monActive_r)
      begin
        monHist_r <= {monHist_r[22:0], netRxBit};
        if (!monReady)
          monWarm_r <= monWarm_r + 5'h01;
      end
      // an error in the clear cycle still counts
      if (monStart || monClrOk)
        errCnt_r <= {19'h00000, monBitErr && !monStart};
      else if (monBitErr && errCnt_r != 20'hfffff)
        errCnt_r <= errCnt_r + 20'h00001;
      if (sendStart || (monStart && !sendActive_r && !monActive_r))
        patSecs_r <= 16'h0000;
      else if (secTick && (sendActive_r || monActive_r) && patSecs_r != 16'hffff)
        patSecs_r <= patSecs_r + 16'h0001;
    end
  end
  // ************************************************************
  // register read
  // ************************************************************
  logic [31:0] statusWord;
  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[ST_LLB +: 4] = llbState_r;
    statusWord[ST_SEND] = sendActive_r;
    statusWord[ST_MON] = monActive_r;
    statusWord[ST_V54] = dclbV54_r;
    statusWord[ST_FT1] = dclbFt1_r;
    statusWord[ST_LINK_UP] = frLinkUp;
    statusWord[ST_REF_LLB] = refLlb_r;
    statusWord[ST_REF_PAT] = refPat_r;
  end
  wire [31:0] cfgWord = {20'h00000, monPat_r, sendPat_r, 2'b00, termLoop_r};
  wire [31:0] rdMux = regAddr == OFS_CFG ? cfgWord :
    regAddr == OFS_USER ? {monUser_r, sendUser_r} :
    regAddr == OFS_STATUS ? statusWord :
    regAddr == OFS_LLB_SECS ? {16'h0000, llbSecs_r} :
    regAddr == OFS_PAT_SECS ? {16'h0000, patSecs_r} :
    regAddr == OFS_ERR_CNT ? {12'h000, errCnt_r} : 32'h0000_0000;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      regRdData <= 32'h0000_0000;
    else
      regRdData <= regRd ? rdMux : 32'h0000_0000;
  end
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  term_loop_a: assert property (termLoop_r[0] |=> termTxBit[0] == $past(termRxBit[0]))
    else $error("terminal loop did not return received bit");
  term_other_a: assert property (termLoop_r[0] && !termLoop_r[1]
    |=> termTxBit[1] == $past(termTxUserBit[1]))
    else $error("other terminal port disturbed by loop");
  llb_refuse_a: assert property (llbIdle && cmdLlbUp && llbBlock |=> llbIdle && refLlb_r)
    else $error("blocked line loop start was accepted");
  llb_limit_a: assert property (llbSending |-> llbSecs_r <= LLB_LIMIT_S)
    else $error("loop code sent past its time limit");
  llb_ack_a: assert property (llbState_r == LLB_UP && farAck && !cmdLlbDown
    |=> llbState_r == LLB_LOOPED ##1 !llbSending)
    else $error("acknowledge did not end activate code");
  channel_data_loop_loop_a: assert property (dclbSlot && netBitEn |=> netTxBit == $past(netRxBit))
    else $error("channel loop did not return slot bit");
  link_down_a: assert property (dclbActive |-> !frLinkUp)
    else $error("link up during channel loop");
  pat_refuse_a: assert property (sendStart && sendBlock |=> !sendActive_r && refPat_r)
    else $error("blocked pattern send was accepted");
  err_insert_a: assert property (insUsed && insPend_r && !cmdIns
    |=> netTxBit != patOut(sendPat_r, $past(sendHist_r)) && !insPend_r)
    else $error("error insert did not flip one bit");
  mon_clear_a: assert property (monClrOk && !monBitErr |=> errCnt_r == 20'h00000 && monActive_r)
    else $error("monitor clear failed or stopped monitor");
  stop_a: assert property (cmdStop |=> !sendActive_r && !monActive_r ##1 !sendActive_r)
    else $error("stop left a pattern test running");
  llb_cycle_c: cover property (llbState_r == LLB_UP ##[1:1000] llbState_r == LLB_LOOPED
    ##[1:1000] llbState_r == LLB_IDLE);
  channel_data_loop_on_c: cover property (!dclbActive ##1 dclbActive);
  err_count_c: cover property (monBitErr ##[1:100] monClrOk);
  insert_c: cover property (insUsed && insPend_r);
endmodule // tlpt_top

// ### bench/tlpt_far_model.sv
`timescale 1ns/1ps
module tlpt_far_model
  import tlpt_pkg::*;
(
  input wire mclk,
  input wire rst_b,
  input wire netTxBit,
  input wire ackEn,
  input wire codeEn,
  input wire [15:0] codeWord,
  input wire [3:0] codeLen,
  output logic netBitEn,
  output logic netRxBit,
  output logic netRxFrSlot,
  output logic farAck,
  output logic farLooped
);
  // ****************
  // remote unit
  // ****************
  logic [1:0] divR;
  logic [3:0] posR;
  logic [9:0] shR;
  wire [9:0] shNxt = {shR[8:0], netTxBit};
  wire [3:0] posNxt = (posR + 4'h1 >= codeLen) ? 4'h0 : posR + 4'h1;
  wire upSeen = shNxt == 10'h021 && !farLooped;
  wire downSeen = shNxt[8:0] == 9'h049 && farLooped;
  assign netRxFrSlot = 1'b1;
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      divR <= 2'h0;
      posR <= 4'h0;
      shR <= 10'h000;
      netBitEn <= 1'b0;
      netRxBit <= 1'b0;
      farAck <= 1'b0;
      farLooped <= 1'b0;
    end
    else
    begin
      divR <= divR + 2'h1;
      netBitEn <= divR == 2'h3;
      farAck <= netBitEn && ackEn && (upSeen || downSeen);
      if (netBitEn)
      begin
        shR <= shNxt;
        posR <= posNxt;
        // otherwise a line loop: whatever we were sent comes back
        netRxBit <= codeEn ? codeWord[codeLen - 4'h1 - posR] : netTxBit;
        farLooped <= upSeen | (farLooped & ~downSeen);
      end
    end
endmodule // tlpt_far_model

// ### bench/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin nCompared++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench
  import tlpt_pkg::*;
;
  logic mclk = 0, rst_b = 0, regWr = 0, regRd = 0, quiet = 0, ackEn = 0, codeEn = 0;
  logic netTxUserBit = 0, netLoopBusy = 0, syncPortBusy = 0, syncPatBusy = 0;
  logic netBitEn, netRxBit, netRxFrSlot, farAck, farLooped, netTxBit, frLinkUp, b;
  logic rdSeen = 0, bitEnD = 0, termChk = 0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData, lastRd, e, m, rnd = 32'hfa56745a;
  logic [15:0] codeWord = 16'h0000;
  logic [3:0] codeLen = 4'h7;
  logic [1:0] termRxBit = 2'h0, termTxUserBit = 2'h0, termTxBit, termCfg = 2'h0, termExp;
  logic [31:0] qExp[$], qMsk[$];
  logic [15:0] tbl[4] = '{V54_ACT_CODE, V54_REL_CODE, FT1_ACT_CODE, FT1_REL_CODE};
  int mismatches = 0, nCompared = 0, zeroCnt = 0, z0;
  always #2.5 mclk = ~mclk;
  tlpt_top #(.SEC_CYCLES(20)) dut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .netBitEn(netBitEn), .netRxBit(netRxBit), .netRxFrSlot(netRxFrSlot),
    .netTxUserBit(netTxUserBit), .netTxBit(netTxBit), .farAck(farAck),
    .netLoopBusy(netLoopBusy), .syncPortBusy(syncPortBusy), .syncPatBusy(syncPatBusy),
    .frLinkUp(frLinkUp), .termRxBit(termRxBit), .termTxUserBit(termTxUserBit),
    .termTxBit(termTxBit));
  tlpt_far_model far (.mclk(mclk), .rst_b(rst_b), .netTxBit(netTxBit), .ackEn(ackEn),
    .codeEn(codeEn), .codeWord(codeWord), .codeLen(codeLen), .netBitEn(netBitEn),
    .netRxBit(netRxBit), .netRxFrSlot(netRxFrSlot), .farAck(farAck), .farLooped(farLooped));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // ****************
  // drivers and monitor
  // ****************
  always @(posedge mclk)
  begin
    rnd <= xs(rnd);
    termRxBit <= rnd[1:0];
    termTxUserBit <= rnd[3:2];
    netTxUserBit <= rnd[4] | quiet;
  end
  always @(posedge mclk)
  begin
    rdSeen <= regRd;
    bitEnD <= netBitEn;
    if (bitEnD && !netTxBit)
      zeroCnt++;
    if (termChk)
      `CHK("termTxBit", termExp, termTxBit)
    termExp = (termRxBit & termCfg) | (termTxUserBit & ~termCfg);
    if (rdSeen)
    begin
      lastRd = regRdData;
      e = qExp.pop_front();
      m = qMsk.pop_front();
      `CHK("regRdData", e, regRdData & m)
    end
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
    qExp.push_back(x & k);
    qMsk.push_back(k);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task bits(input int n);
    repeat (n * 4) @(posedge mclk);
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    rd(OFS_CFG, CFG_RST, '1);
    rd(OFS_USER, USER_RST, '1);
    rd(OFS_STATUS, 32'h101, 32'h7ff);
    rd(8'h1c, 32'h0, '1);
    for (int p = 1; p < 3; p++)
    begin
      wr(OFS_CFG, p);
      termCfg = p[1:0];
      bits(1);
      termChk = 1'b1;
      bits(8);
      termChk = 1'b0;
    end
    wr(OFS_CFG, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      {syncPatBusy, syncPortBusy, netLoopBusy} <= 3'h1 << i;
      wr(OFS_CMD, 32'h1);
      rd(OFS_STATUS, 32'h201, 32'h20f);
      wr(OFS_CMD, 32'h4);
      rd(OFS_STATUS, 32'h400, 32'h410);
    end
    {syncPatBusy, syncPortBusy, netLoopBusy} <= 3'h0;
    for (int p = 0; p < 11; p++)
    begin
      wr(OFS_USER, {2{rnd[15:0]}});
      wr(OFS_CFG, (p << 8) | (p << 4));
      wr(OFS_CMD, 32'h4);
      bits(40);
      wr(OFS_CMD, 32'h8);
      bits(40);
      rd(OFS_STATUS, 32'h30, 32'h30);
      rd(OFS_ERR_CNT, 32'h0, 32'hfffff);
      wr(OFS_CMD, 32'h10);
    end
    wr(OFS_CFG, 32'h220);
    wr(OFS_CMD, 32'hc);
    bits(40);
    z0 = zeroCnt;
    wr(OFS_CMD, 32'h20);
    bits(20);
    `CHK("zeros", 1, zeroCnt - z0)
    wr(OFS_CMD, 32'h40);
    rd(OFS_ERR_CNT, 32'h0, 32'h0);
    `CHK("errCount", 1'b1, lastRd != 0)
    rd(OFS_PAT_SECS, 32'h0, 32'h0);
    `CHK("patSecs", 1'b1, lastRd != 0)
    wr(OFS_CFG, 32'h660);
    wr(OFS_CMD, 32'h20);
    bits(20);
    wr(OFS_CMD, 32'h40);
    rd(OFS_ERR_CNT, 32'h0, '1);
    rd(OFS_STATUS, 32'h30, 32'h30);
    wr(OFS_CMD, 32'h10);
    rd(OFS_STATUS, 32'h0, 32'h30);
    for (int k = 0; k < 4; k++)
    begin
      codeWord <= tbl[k];
      codeLen <= k < 2 ? 4'(V54_LEN) : 4'(FT1_LEN);
      codeEn <= 1'b1;
      bits(300);
      rd(OFS_STATUS, k[0] ? 32'h0 : (k < 2 ? 32'h40 : 32'h80), 32'hc0);
      `CHK("frLinkUp", k[0], frLinkUp)
      for (int j = 0; j < 8 && !k[0]; j++)
      begin
        @(posedge mclk iff netBitEn);
        b = netRxBit;
        #1;
        `CHK("echo", b, netTxBit)
      end
    end
    codeEn <= 1'b0;
    quiet <= 1'b1;
    ackEn <= 1'b1;
    wr(OFS_CMD, 32'h1);
    rd(OFS_STATUS, 32'h2, 32'hf);
    bits(30);
    rd(OFS_STATUS, 32'h4, 32'hf);
    `CHK("farLooped", 1'b1, farLooped)
    wr(OFS_CMD, 32'h2);
    rd(OFS_STATUS, 32'h8, 32'hf);
    bits(30);
    rd(OFS_STATUS, 32'h1, 32'hf);
    `CHK("farLooped", 1'b0, farLooped)
    ackEn <= 1'b0;
    wr(OFS_CMD, 32'h1);
    repeat (88) @(posedge mclk);
    rd(OFS_LLB_SECS, 32'h4, 32'hfffffffe);
    repeat (150) @(posedge mclk);
    rd(OFS_STATUS, 32'h0, 32'h2);
    tally_and_finish;
  end
endmodule // testbench
